// file: dual_timer_map.svh
// Purpose: Constants for the dual timer and signal routing block
// Assumes: Single 100 MHz clock, synchronous active-high reset
// Notes:   Mode and clock-source codes are local encodings
`ifndef DUAL_TIMER_MAP_SVH
`define DUAL_TIMER_MAP_SVH

`define CNT_W            16
`define RADIO_DIV_DFLT   16'd192
`define CNT_RST          16'h0000
`define SRC_EXT_PIN      2'h0
`define SRC_AUX          2'h1
`define SRC_SUBMAIN      2'h2
`define SRC_RADIO        2'h3
`define CNT_MODE_STOP    2'h0
`define CNT_MODE_UP      2'h1
`define CNT_MODE_CONT    2'h2
`define CNT_MODE_UPDN    2'h3
`define OUT_SET          3'h1
`define OUT_TOG_RST      3'h2
`define OUT_SET_RST      3'h3
`define OUT_TOGGLE       3'h4
`define OUT_RESET        3'h5
`define OUT_TOG_SET      3'h6
`define OUT_RST_SET      3'h7

`endif

// file: dual_timer_pkg.sv
// Purpose: Types shared by the dual timer block
// Assumes: Nothing beyond the map header
// Notes:   Channel configuration travels as one packed struct
package dual_timer_pkg;

   typedef struct packed {
      logic        capture_mode;
      logic [1:0]  capture_edge;
      logic        use_alt_input;
      logic [2:0]  out_mode;
      logic        out_value;
      logic [15:0] compare;
   } chan_cfg_s;

   typedef struct packed {
      logic [1:0]  clk_src;
      logic [1:0]  cnt_mode;
      logic        clear;
   } timer_cfg_s;

endpackage

// file: dual_timer_routing.sv
// Purpose: Two timers counting up or up-down with capture/compare channels and their
//          internal signal routing
// Assumes: All count clocks and pin inputs are asynchronous to ref_clk and
//          are slower than half its rate
// Notes:   Configuration arrives as plain ports, no software register file
//
// Behaviour
// - Five-channel timer: 16-bit counter, five channels
// - Three-channel timer: 16-bit counter, three channels
// - Capture, compare, PWM and interval timing
// - Overflow and per-channel interrupt requests
// - Count clock: pin, aux, submain, radio-divided
// - Five-channel channel one triggers converter sampling
// - Three-channel channel zero bridges radio async data
`timescale 1ns/1ps
`include "dual_timer_map.svh"

//////////////////////////////////////////////////////////////////////////////
module timer_core
   import dual_timer_pkg::*;
#(
   parameter int CH    = 5,
   parameter int CNT_W = `CNT_W
) (
   input  wire logic                ref_clk,
   input  wire logic                sys_rst,
   input  wire logic [3:0]          src_sync,
   input  wire timer_cfg_s          tcfg,
   input  wire chan_cfg_s [CH-1:0]  ccfg,
   input  wire logic [CH-1:0]       cap_pin,
   input  wire logic [CH-1:0]       cap_alt,
   output logic [CNT_W-1:0]         count,
   output logic [CH-1:0][CNT_W-1:0] captured,
   output logic [CH-1:0]            chan_out,
   output logic                     ovf_irq,
   output logic [CH-1:0]            chan_irq
);

   logic             src_prev;
   logic             down;
   logic [CNT_W-1:0] next_count;
   logic             next_down;

   wire logic             src_lvl  = src_sync[tcfg.clk_src];
   wire logic             tick     = src_lvl & ~src_prev;
   // Up mode wraps at channel zero compare, giving the interval period
   wire logic [CNT_W-1:0] top      = (tcfg.cnt_mode == `CNT_MODE_CONT) ?
                                     {CNT_W{1'b1}} : ccfg[0].compare;
   wire logic             at_top   = (count == top);
   wire logic             run      = tick && (tcfg.cnt_mode != `CNT_MODE_STOP);
   wire logic             is_updn  = (tcfg.cnt_mode == `CNT_MODE_UPDN);
   wire logic             wrap     = run && !is_updn && at_top;
   wire logic             zero_hit = run && is_updn && down && (count == 16'h0001);

   always_comb begin
      next_count = count;
      next_down  = down;
      if (tcfg.clear) begin
         next_count = `CNT_RST;
         next_down  = 1'b0;
      end else if (run) begin
         if (is_updn) begin
            if (!down && at_top) begin
               next_count = count - 16'h0001;
               next_down  = 1'b1;
            end else if (down && count == 16'h0001) begin
               next_count = `CNT_RST;
               next_down  = 1'b0;
            end else begin
               next_count = down ? count - 16'h0001 : count + 16'h0001;
            end
         end else begin
            next_count = at_top ? `CNT_RST : count + 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         src_prev <= 1'b0;
         count    <= `CNT_RST;
         down     <= 1'b0;
         ovf_irq  <= 1'b0;
      end else begin
         src_prev <= src_lvl;
         count    <= next_count;
         down     <= next_down;
         ovf_irq  <= wrap | zero_hit;
      end
   end

   genvar i;
   generate
      for (i = 0; i < CH; i++) begin : g_chan
         logic in_prev;
         wire logic in_lvl = ccfg[i].use_alt_input ? cap_alt[i] : cap_pin[i];
         wire logic rise   = in_lvl & ~in_prev;
         wire logic fall   = ~in_lvl & in_prev;
         wire logic cap_ev = ccfg[i].capture_mode &&
                             ((ccfg[i].capture_edge[0] && rise) ||
                              (ccfg[i].capture_edge[1] && fall));
         wire logic eq_ev  = !ccfg[i].capture_mode && run &&
                             (next_count == ccfg[i].compare);
         // Second output event: period end for channels above zero
         wire logic alt_ev = !ccfg[i].capture_mode && (wrap || zero_hit);
         logic next_out;

         always_comb begin
            next_out = chan_out[i];
            if (ccfg[i].out_mode == 3'h0) begin
               next_out = ccfg[i].out_value;
            end else if (eq_ev) begin
               case (ccfg[i].out_mode)
                  `OUT_SET, `OUT_SET_RST:     next_out = 1'b1;
                  `OUT_RESET, `OUT_RST_SET:   next_out = 1'b0;
                  default:                    next_out = ~chan_out[i];
               endcase
            end else if (alt_ev && i != 0) begin
               case (ccfg[i].out_mode)
                  `OUT_TOG_RST, `OUT_SET_RST: next_out = 1'b0;
                  `OUT_RST_SET, `OUT_TOG_SET: next_out = 1'b1;
                  default:                    next_out = chan_out[i];
               endcase
            end
         end

         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               in_prev     <= 1'b0;
               captured[i] <= `CNT_RST;
               chan_out[i] <= 1'b0;
               chan_irq[i] <= 1'b0;
            end else begin
               in_prev     <= in_lvl;
               chan_out[i] <= next_out;
               chan_irq[i] <= cap_ev | eq_ev;
               if (cap_ev) begin
                  captured[i] <= count;
               end
            end
         end
      end
   endgenerate

endmodule

//////////////////////////////////////////////////////////////////////////////
module dual_timer_routing
   import dual_timer_pkg::*;
#(
   parameter logic [15:0] RADIO_DIV = `RADIO_DIV_DFLT
) (
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic [1:0]        external_count_clock_pin,
   input  wire logic              aux_clock,
   input  wire logic              submain_clock,
   input  wire logic              radio_crystal_clock,
   input  wire logic              radio_div_override_en,
   input  wire logic [15:0]       radio_div_override,
   input  wire logic              comparator_output,
   input  wire logic              radio_general_output_one,
   input  wire logic              radio_general_output_two,
   input  wire logic              radio_async_data_out,
   input  wire timer_cfg_s        five_tcfg,
   input  wire chan_cfg_s [4:0]   five_ccfg,
   input  wire logic [4:0]        five_cap_pin,
   input  wire timer_cfg_s        three_tcfg,
   input  wire chan_cfg_s [2:0]   three_ccfg,
   input  wire logic [2:0]        three_cap_pin,
   output logic [15:0]            five_count,
   output logic [4:0][15:0]       five_captured,
   output logic [4:0]             five_out,
   output logic                   five_ovf_irq,
   output logic [4:0]             five_chan_irq,
   output logic [15:0]            three_count,
   output logic [2:0][15:0]       three_captured,
   output logic [2:0]             three_out,
   output logic                   three_ovf_irq,
   output logic [2:0]             three_chan_irq,
   output logic                   converter_sample_trigger,
   output logic                   radio_async_data_in
);

   // Synchronise every asynchronous level before use
   localparam int NS = 17;
   logic [NS-1:0] meta;
   logic [NS-1:0] sync;
   wire  logic [NS-1:0] raw = {five_cap_pin, three_cap_pin, external_count_clock_pin,
                               aux_clock, submain_clock, radio_crystal_clock,
                               comparator_output, radio_general_output_one,
                               radio_general_output_two, radio_async_data_out};
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         meta <= '0;
         sync <= '0;
      end else begin
         meta <= raw;
         sync <= meta;
      end
   end
   wire logic [4:0] s_five_pin  = sync[16:12];
   wire logic [2:0] s_three_pin = sync[11:9];
   wire logic [1:0] s_ext       = sync[8:7];
   wire logic s_aux   = sync[6];
   wire logic s_sub   = sync[5];
   wire logic s_rfc   = sync[4];
   wire logic s_cmp   = sync[3];
   wire logic s_g1    = sync[2];
   wire logic s_g2    = sync[1];
   wire logic s_async = sync[0];

   // Radio crystal divided; square wave so edge detection downstream works
   logic [15:0] rf_cnt;
   logic        radio_derived_count_clock;
   logic        rfc_prev;
   wire  logic [15:0] div_sel = radio_div_override_en ? radio_div_override : RADIO_DIV;
   wire  logic [15:0] half    = (div_sel >> 1) == 16'h0000 ? 16'h0001 : div_sel >> 1;
   wire  logic rf_rise = s_rfc & ~rfc_prev;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rfc_prev                  <= 1'b0;
         rf_cnt                    <= 16'h0000;
         radio_derived_count_clock <= 1'b0;
      end else begin
         rfc_prev <= s_rfc;
         if (rf_rise) begin
            if (rf_cnt + 16'h0001 >= half) begin
               rf_cnt                    <= 16'h0000;
               radio_derived_count_clock <= ~radio_derived_count_clock;
            end else begin
               rf_cnt <= rf_cnt + 16'h0001;
            end
         end
      end
   end

   wire logic [3:0] five_src  = {radio_derived_count_clock, s_sub, s_aux, s_ext[0]};
   wire logic [3:0] three_src = {radio_derived_count_clock, s_sub, s_aux, s_ext[1]};
   wire logic [4:0] five_alt  = {s_g2, s_g1, s_aux, s_cmp, 1'b0};
   wire logic [2:0] three_alt = {s_aux, s_cmp, s_async};

   timer_core #(.CH(5), .CNT_W(16)) timer_five_channel (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .src_sync (five_src),
      .tcfg     (five_tcfg),
      .ccfg     (five_ccfg),
      .cap_pin  (s_five_pin),
      .cap_alt  (five_alt),
      .count    (five_count),
      .captured (five_captured),
      .chan_out (five_out),
      .ovf_irq  (five_ovf_irq),
      .chan_irq (five_chan_irq)
   );

   timer_core #(.CH(3), .CNT_W(16)) timer_three_channel (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .src_sync (three_src),
      .tcfg     (three_tcfg),
      .ccfg     (three_ccfg),
      .cap_pin  (s_three_pin),
      .cap_alt  (three_alt),
      .count    (three_count),
      .captured (three_captured),
      .chan_out (three_out),
      .ovf_irq  (three_ovf_irq),
      .chan_irq (three_chan_irq)
   );

   assign converter_sample_trigger = five_out[1];
   assign radio_async_data_in      = three_out[0];

endmodule

// file: dual_timer_sva.sv
// Purpose: Port-level checks for the dual timer block
// Assumes: Configuration held steady while a check is armed
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`include "dual_timer_map.svh"
////////////////////////////////////////////////////////////
module dual_timer_sva
   import dual_timer_pkg::*;
(
   input wire logic            ref_clk,
   input wire logic            sys_rst,
   input wire logic            aux_clock,
   input wire timer_cfg_s      five_tcfg,
   input wire timer_cfg_s      three_tcfg,
   input wire chan_cfg_s [4:0] five_ccfg,
   input wire logic [15:0]     five_count,
   input wire logic [15:0]     three_count,
   input wire logic [4:0]      five_out,
   input wire logic [2:0]      three_out,
   input wire logic            five_ovf_irq,
   input wire logic            three_ovf_irq,
   input wire logic [4:0]      five_chan_irq,
   input wire logic            converter_sample_trigger,
   input wire logic            radio_async_data_in
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_five_cont;
      five_tcfg.cnt_mode == `CNT_MODE_CONT && !five_tcfg.clear;
   endsequence
   sequence s_aux_rise;
      five_tcfg.clk_src == `SRC_AUX && five_tcfg.cnt_mode == `CNT_MODE_CONT
         && !five_tcfg.clear && $rose(aux_clock);
   endsequence
   property p_trig; converter_sample_trigger == five_out[1]; endproperty
   a_trig: assert property (p_trig) else $error("trigger not channel one");
   property p_async; radio_async_data_in == three_out[0]; endproperty
   a_async: assert property (p_async) else $error("async input not channel zero");
   property p_five_ovf; five_ovf_irq |-> five_count == `CNT_RST ##1 !five_ovf_irq; endproperty
   a_five_ovf: assert property (p_five_ovf) else $error("five overflow bad");
   property p_three_ovf; three_ovf_irq |-> three_count == `CNT_RST ##1 !three_ovf_irq; endproperty
   a_three_ovf: assert property (p_three_ovf) else $error("three overflow bad");
   property p_five_step;
      s_five_cont[*2] |-> five_count == $past(five_count)
         || five_count == $past(five_count) + 16'h0001;
   endproperty
   a_five_step: assert property (p_five_step) else $error("five count jumped");
   property p_three_stop;
      (three_tcfg.cnt_mode == `CNT_MODE_STOP && !three_tcfg.clear)[*2] |-> $stable(three_count);
   endproperty
   a_three_stop: assert property (p_three_stop) else $error("three count moved");
   property p_five_clear; five_tcfg.clear[*2] |-> five_count == `CNT_RST; endproperty
   a_five_clear: assert property (p_five_clear) else $error("clear ignored");
   property p_cmp_irq;
      five_chan_irq[1] && !five_ccfg[1].capture_mode |-> five_count == five_ccfg[1].compare;
   endproperty
   a_cmp_irq: assert property (p_cmp_irq) else $error("compare irq off match");
   property p_irq_pulse;
      five_chan_irq != 5'h00 |=> (five_chan_irq & $past(five_chan_irq)) == 5'h00;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("channel irq too long");
   property p_aux_tick; s_aux_rise |-> ##[2:5] $changed(five_count); endproperty
   a_aux_tick: assert property (p_aux_tick) else $error("aux edge not counted");
endmodule

// file: on_chip_sources.sv
// Purpose: Behavioural on-chip clock sources facing the timers
// Assumes: Each burst gives a set number of rising edges
// Notes:   Clocks stand low between bursts, like gated clocks
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module on_chip_sources (
   input  wire logic        ref_clk,
   input  wire logic [2:0]  start,
   input  wire logic [15:0] rises,
   output logic             aux_clock,
   output logic             submain_clock,
   output logic             radio_crystal_clock,
   output logic             busy
);
   logic [2:0]  lvl = 3'h0;
   logic [2:0]  ph = 3'h0;
   logic [15:0] left [3] = '{default: 16'h0000};
   // Two cycles high, two low: fastest the synchronisers accept
   always @(posedge ref_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (start[i]) left[i] <= rises;
         else if (left[i] != 16'h0000 || lvl[i]) begin
            ph[i] <= ~ph[i];
            if (ph[i]) begin
               lvl[i] <= ~lvl[i];
               if (!lvl[i]) left[i] <= left[i] - 16'h0001;
            end
         end
      end
   end
   assign aux_clock = lvl[0];
   assign submain_clock = lvl[1];
   assign radio_crystal_clock = lvl[2];
   assign busy = (|lvl) || (left[0] | left[1] | left[2]) != 16'h0000;
endmodule

// file: testbench.sv
// Purpose: Self-checking bench for the dual timer block
// Assumes: Radio divider shortened to 4 for run time
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`include "dual_timer_map.svh"
////////////////////////////////////////////////////////////
module testbench
   import dual_timer_pkg::*;
;
   localparam logic [15:0] DIV = 16'h0004;
   logic             ref_clk = 1'b0;
   logic             sys_rst = 1'b1;
   logic [1:0]       pin = 2'h0;
   logic             div_en = 1'b0;
   logic [3:0]       alt = 4'h0;
   logic [2:0]       start = 3'h0;
   logic [15:0]      rises = 16'h0000;
   timer_cfg_s       ft, tt;
   chan_cfg_s [4:0]  fc;
   chan_cfg_s [2:0]  tc;
   logic             aux, sub, xtal, busy, fovf, tovf, trig, adin;
   logic [15:0]      fcnt, tcnt;
   logic [4:0][15:0] fcap;
   logic [2:0][15:0] tcap;
   logic [4:0]       fout, firq;
   logic [2:0]       tout, tirq;
   int               errors = 0;
   int               checks_done = 0;
   int               cycles = 0;
   int               nirq [10];
   on_chip_sources sources (.ref_clk(ref_clk), .start(start), .rises(rises), .aux_clock(aux),
      .submain_clock(sub), .radio_crystal_clock(xtal), .busy(busy));
   dual_timer_routing #(.RADIO_DIV(DIV)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .external_count_clock_pin(pin), .aux_clock(aux), .submain_clock(sub),
      .radio_crystal_clock(xtal), .radio_div_override_en(div_en), .radio_div_override(16'h0006),
      .comparator_output(alt[0]), .radio_general_output_one(alt[1]),
      .radio_general_output_two(alt[2]), .radio_async_data_out(alt[3]), .five_tcfg(ft),
      .five_ccfg(fc), .five_cap_pin({5{pin[0]}}), .three_tcfg(tt), .three_ccfg(tc),
      .three_cap_pin({3{pin[1]}}), .five_count(fcnt), .five_captured(fcap), .five_out(fout),
      .five_ovf_irq(fovf), .five_chan_irq(firq), .three_count(tcnt), .three_captured(tcap),
      .three_out(tout), .three_ovf_irq(tovf), .three_chan_irq(tirq),
      .converter_sample_trigger(trig), .radio_async_data_in(adin));
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      for (int k = 0; k < 10; k++) nirq[k] += int'({tovf, fovf, tirq, firq} >> k) & 1;
      cycles++;
      if (cycles == 5000) begin
         errors++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic cfg(input logic [1:0] src, input logic [1:0] mode);
      ft = '{src, mode, 1'b1};
      tt = ft;
      cyc(3);
      ft.clear = 1'b0;
      tt = ft;
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         pin = 2'h3;
         cyc(3);
         pin = 2'h0;
         cyc(3);
      end
      cyc(6);
   endtask
   task automatic run(input int i, input logic [15:0] n);
      start[i] = 1'b1;
      rises = n;
      cyc(1);
      start[i] = 1'b0;
      while (busy) cyc(1);
      cyc(8);
   endtask
   task automatic t_radio();
      cfg(`SRC_RADIO, `CNT_MODE_CONT);
      run(2, DIV << 2);
      chk("radio divide", {16'h4, 16'h4}, {fcnt, tcnt});
      div_en = 1'b1;
      run(2, 16'h000C);
      chk("radio override", {16'h6, 16'h6}, {fcnt, tcnt});
      div_en = 1'b0;
   endtask
   task automatic t_sources();
      for (int s = 0; s < 3; s++) begin
         cfg(s[1:0], `CNT_MODE_CONT);
         if (s == 0) tick(5);
         else run(s - 1, 16'(s + 5));
         chk("source count", {16'(s + 5), 16'(s + 5)}, {fcnt, tcnt});
      end
   endtask
   task automatic t_compare();
      for (int k = 0; k < 5; k++) begin
         fc[k] = '{1'b0, 2'h0, 1'b0, `OUT_TOGGLE, 1'b0, (k == 0) ? 16'h0006 : 16'(k)};
         if (k < 3) tc[k] = fc[k];
      end
      cfg(`SRC_EXT_PIN, `CNT_MODE_UP);
      nirq = '{default: 0};
      tick(7);
      for (int k = 0; k < 10; k++) chk("irq count", 1, nirq[k]);
      chk("outputs", 8'hFF, {tout, fout});
      chk("routed outputs", 2'h3, {adin, trig});
   endtask
   task automatic t_capture();
      for (int k = 0; k < 5; k++) begin
         fc[k] = '{1'b1, 2'b01, 1'b1, 3'h0, 1'b0, 16'h0000};
         if (k < 3) tc[k] = fc[k];
      end
      cfg(`SRC_EXT_PIN, `CNT_MODE_CONT);
      for (int i = 0; i < 5; i++) begin
         tick(1);
         if (i == 1) run(0, 16'h0001);
         else alt[i - (i > 1)] = 1'b1;
         cyc(8);
      end
      ft.cnt_mode = `CNT_MODE_STOP;
      tt = ft;
      // Channel zero moves to its own pin, falling edge only
      fc[0] = '{1'b1, 2'b10, 1'b0, 3'h0, 1'b0, 16'h0000};
      tick(2);
      chk("stopped", {16'h5, 16'h5}, {fcnt, tcnt});
      chk("five capture", {16'h4, 16'h3, 16'h2, 16'h1, 16'h5}, fcap);
      chk("three capture", {16'h2, 16'h1, 16'h5}, tcap);
   endtask
   task automatic t_pwm();
      fc[0] = '{1'b0, 2'h0, 1'b0, `OUT_SET, 1'b0, 16'h0004};
      fc[1] = '{1'b0, 2'h0, 1'b0, `OUT_TOG_RST, 1'b0, 16'h0002};
      fc[2] = '{1'b0, 2'h0, 1'b0, `OUT_SET_RST, 1'b0, 16'h0002};
      fc[3] = '{1'b0, 2'h0, 1'b0, `OUT_RST_SET, 1'b0, 16'h0002};
      fc[4] = '{1'b0, 2'h0, 1'b0, `OUT_TOG_SET, 1'b0, 16'h0002};
      tc = fc[2:0];
      cfg(`SRC_EXT_PIN, `CNT_MODE_UPDN);
      nirq = '{default: 0};
      // Up-down to four: counts 1,2,3,4,3,2,1,0 over eight ticks
      tick(2);
      chk("pwm rising", {16'h2, 16'h2, 8'hD6}, {fcnt, tcnt, tout, fout});
      tick(6);
      chk("pwm falling", {16'h0, 16'h0, 8'h39}, {fcnt, tcnt, tout, fout});
      chk("updown overflow", 2, nirq[8] + nirq[9]);
   endtask
   initial begin
      ft = '0;
      tt = '0;
      fc = '0;
      tc = '0;
      cyc(6);
      sys_rst = 1'b0;
      cyc(2);
      t_radio();
      t_sources();
      t_compare();
      t_capture();
      t_pwm();
      give_verdict();
   end
endmodule
bind dual_timer_routing dual_timer_sva chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .aux_clock(aux_clock), .five_tcfg(five_tcfg), .three_tcfg(three_tcfg),
   .five_ccfg(five_ccfg), .five_count(five_count), .three_count(three_count),
   .five_out(five_out), .three_out(three_out), .five_ovf_irq(five_ovf_irq),
   .three_ovf_irq(three_ovf_irq), .five_chan_irq(five_chan_irq),
   .converter_sample_trigger(converter_sample_trigger),
   .radio_async_data_in(radio_async_data_in));
